/* File: rtl/rpe_root_port_err.sv */
// root port error logging, root error control and access control registers
`timescale 1ns/10ps
// Notes on behaviour
// (RULE1) header dwords three and four held read-only
// (RULE2) enabled error class raises the interrupt
// (RULE3) first correctable message sets bit 0
// (RULE4) repeat correctable message sets bit 1
// (RULE5) first uncorrectable message sets bit 2
// (RULE6) repeat uncorrectable message sets bit 3
// (RULE7) bit 4 when first uncorrectable is fatal
// (RULE8) bit 5 once any non-fatal seen
// (RULE9) bit 6 once any fatal seen
// (RULE10) status, ids, logs survive warm reset only
// (RULE11) message number read-only in bits 31:27
// (RULE12) first correctable requester id to low half
// (RULE13) first uncorrectable requester id to high half
// (RULE14) capability header id d, version 1, end
// (RULE15) capability bits 0 to 6 read zero
// (RULE16) egress size zero means 256 bits
// (RULE17) bit 0 checks requester bus range
// (RULE18) bit 1 blocks translated upstream memory
// (RULE19) bit 2 redirects peer requests upstream
// (RULE20) bit 3 redirects strict peer read completions
// (RULE21) bit 4 forwards lower redirected traffic up
// (RULE22) bit 6 exempts translated; bit 5 read-only
// (RULE23) software clears status by writing ones
module rpe_root_port_err
    import rpe_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic WARM_RESET_I,
    input wire logic CFG_WR_I,
    input wire logic CFG_RD_I,
    input wire logic [11:0] CFG_ADDR_I,
    input wire logic [3:0] CFG_BE_I,
    input wire logic [31:0] CFG_WDATA_I,
    output logic [31:0] CFG_RDATA_O,
    output logic CFG_RD_ACK_O,
    input wire logic MSG_VALID_I,
    input wire logic [1:0] MSG_CLASS_I,
    input wire logic [15:0] MSG_REQ_ID_I,
    input wire logic HDR_LOG_WE_I,
    input wire logic [31:0] HDR_DW2_I,
    input wire logic [31:0] HDR_DW3_I,
    input wire logic [4:0] MSG_NUM_I,
    output logic ERR_IRQ_O,
    input wire logic [7:0] SEC_BUS_I,
    input wire logic [7:0] SUB_BUS_I,
    input wire logic UP_REQ_I,
    input wire logic [7:0] UP_REQ_BUS_I,
    input wire logic UP_MEM_REQ_I,
    input wire logic [1:0] UP_AT_I,
    input wire logic P2P_REQ_I,
    input wire logic P2P_TRANSLATED_I,
    input wire logic P2P_CPL_I,
    input wire logic CPL_IS_READ_I,
    input wire logic CPL_RELAXED_I,
    input wire logic LOWER_REDIRECTED_I,
    output logic SRC_VIOLATION_O,
    output logic XLAT_BLOCKED_O,
    output logic REQ_REDIRECT_O,
    output logic CPL_REDIRECT_O,
    output logic UP_FORWARD_O
);

    // address decode shared by reads and writes
    function automatic logic hit(
        input logic [11:0] addr,
        input logic [11:0] off
    );
        hit = (addr[11:2] == off[11:2]);
    endfunction

    logic [31:0] hdr_dw2_q;
    logic [31:0] hdr_dw3_q;
    logic [CMD_W-1:0] cmd_q;
    logic [STS_W-1:0] sts_q;
    logic [STS_W-1:0] sts_d;
    logic [REQ_ID_W-1:0] cor_src_q;
    logic [REQ_ID_W-1:0] uncor_src_q;
    logic [CTL_W-1:0] ctl_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic rd_ack_q;
    logic irq_q;
    logic [STS_W-1:0] w1c;
    logic msg_cor;
    logic msg_nonfatal;
    logic msg_fatal;
    logic msg_uncor;
    logic wr_cmd;
    logic wr_sts;
    logic wr_ctl;
    logic [31:0] acs_hdr;
    logic [15:0] acs_cap;

    assign msg_cor = MSG_VALID_I && (MSG_CLASS_I == RPE_MSG_COR);
    assign msg_nonfatal = MSG_VALID_I
        && (MSG_CLASS_I == RPE_MSG_NONFATAL);
    assign msg_fatal = MSG_VALID_I && (MSG_CLASS_I == RPE_MSG_FATAL);
    assign msg_uncor = msg_nonfatal || msg_fatal;

    assign wr_cmd = CFG_WR_I && CFG_BE_I[0]
        && hit(CFG_ADDR_I, ROOT_ERR_CMD_OFF);
    assign wr_sts = CFG_WR_I && CFG_BE_I[0]
        && hit(CFG_ADDR_I, ROOT_ERR_STS_OFF);
    // control halfword sits in the upper lanes of the 0x194 dword
    assign wr_ctl = CFG_WR_I && CFG_BE_I[2]
        && hit(CFG_ADDR_I, ACS_CTL_OFF);

    // ones written to the status byte clear flags
    assign w1c = wr_sts ? CFG_WDATA_I[STS_W-1:0] : '0; // [RULE23]

    // header log; warm reset leaves it alone
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            hdr_dw2_q <= LOG_RESET; // [RULE10]
            hdr_dw3_q <= LOG_RESET;
        end else if (HDR_LOG_WE_I) begin
            hdr_dw2_q <= HDR_DW2_I; // [RULE1]
            hdr_dw3_q <= HDR_DW3_I; // [RULE1]
        end
    end

    // root error command, cleared by either reset
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || WARM_RESET_I) begin
            cmd_q <= '0;
        end else if (wr_cmd) begin
            cmd_q <= CFG_WDATA_I[CMD_W-1:0];
        end
    end

    // status flags: a set in the same cycle beats a clear
    always_comb begin
        sts_d = sts_q & ~w1c;
        if (msg_cor) begin
            if (!sts_q[STS_COR_BIT]) begin
                sts_d[STS_COR_BIT] = 1'b1; // [RULE3]
            end else begin
                sts_d[STS_COR_BIT] = 1'b1;
                sts_d[STS_MULT_COR_BIT] = 1'b1; // [RULE4]
            end
        end
        if (msg_uncor) begin
            if (!sts_q[STS_UNCOR_BIT]) begin
                sts_d[STS_UNCOR_BIT] = 1'b1; // [RULE5]
                if (msg_fatal) begin
                    sts_d[STS_FIRST_FATAL_BIT] = 1'b1; // [RULE7]
                end
            end else begin
                sts_d[STS_UNCOR_BIT] = 1'b1;
                sts_d[STS_MULT_UNCOR_BIT] = 1'b1; // [RULE6]
            end
        end
        if (msg_nonfatal) begin
            sts_d[STS_NONFATAL_SEEN_BIT] = 1'b1; // [RULE8]
        end
        if (msg_fatal) begin
            sts_d[STS_FATAL_SEEN_BIT] = 1'b1; // [RULE9]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            sts_q <= '0; // [RULE10]
        end else begin
            sts_q <= sts_d;
        end
    end

    // requester ids of the first correctable and first uncorrectable message
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            cor_src_q <= ID_RESET; // [RULE10]
        end else if (msg_cor && !sts_q[STS_COR_BIT]) begin
            cor_src_q <= MSG_REQ_ID_I; // [RULE12]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            uncor_src_q <= ID_RESET; // [RULE10]
        end else if (msg_uncor && !sts_q[STS_UNCOR_BIT]) begin
            uncor_src_q <= MSG_REQ_ID_I; // [RULE13]
        end
    end

    // interrupt level from enabled classes with a flag standing
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || WARM_RESET_I) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (cmd_q[CMD_COR_EN_BIT]
                    && sts_q[STS_COR_BIT])
                || (cmd_q[CMD_NONFATAL_EN_BIT]
                    && sts_q[STS_NONFATAL_SEEN_BIT])
                || (cmd_q[CMD_FATAL_EN_BIT]
                    && sts_q[STS_FATAL_SEEN_BIT]); // [RULE2]
        end
    end

    assign ERR_IRQ_O = irq_q;

    // access control enables; bit 5 never takes a write
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I || WARM_RESET_I) begin
            ctl_q <= '0;
        end else if (wr_ctl) begin
            ctl_q <= CFG_WDATA_I[16 +: CTL_W] & CTL_WR_MASK; // [RULE22]
        end
    end

    assign acs_hdr = {ACS_NEXT_PTR, ACS_CAP_VER, ACS_CAP_ID}; // [RULE14]
    assign acs_cap = {ACS_EGRESS_SIZE, 1'b0, ACS_CAP_BITS}; // [RULE15]

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = '0;
        if (hit(CFG_ADDR_I, HDR_LOG_DW2_OFF)) begin
            rdata_d = hdr_dw2_q; // [RULE1]
        end else if (hit(CFG_ADDR_I, HDR_LOG_DW3_OFF)) begin
            rdata_d = hdr_dw3_q; // [RULE1]
        end else if (hit(CFG_ADDR_I, ROOT_ERR_CMD_OFF)) begin
            rdata_d[CMD_W-1:0] = cmd_q;
        end else if (hit(CFG_ADDR_I, ROOT_ERR_STS_OFF)) begin
            rdata_d[STS_W-1:0] = sts_q;
            rdata_d[STS_MSGNUM_LSB +: MSGNUM_W] = MSG_NUM_I; // [RULE11]
        end else if (hit(CFG_ADDR_I, ERR_SRC_ID_OFF)) begin
            rdata_d[SRC_COR_LSB +: REQ_ID_W] = cor_src_q;
            rdata_d[SRC_UNCOR_LSB +: REQ_ID_W] = uncor_src_q;
        end else if (hit(CFG_ADDR_I, ACS_HDR_OFF)) begin
            rdata_d = acs_hdr;
        end else if (hit(CFG_ADDR_I, ACS_CAP_OFF)) begin
            rdata_d[15:0] = acs_cap; // [RULE16]
            rdata_d[16 +: CTL_W] = ctl_q;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            rdata_q <= '0;
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= CFG_RD_I;
            if (CFG_RD_I) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign CFG_RDATA_O = rdata_q;
    assign CFG_RD_ACK_O = rd_ack_q;

    // forwarding decisions driven by the enables
    assign SRC_VIOLATION_O = ctl_q[CTL_SRC_VALID_BIT] && UP_REQ_I
        && ((UP_REQ_BUS_I < SEC_BUS_I)
        || (UP_REQ_BUS_I > SUB_BUS_I)); // [RULE17]
    assign XLAT_BLOCKED_O = ctl_q[CTL_XLAT_BLOCK_BIT] && UP_MEM_REQ_I
        && (UP_AT_I != 2'h0); // [RULE18]
    assign REQ_REDIRECT_O = ctl_q[CTL_REQ_REDIR_BIT] && P2P_REQ_I
        && !(ctl_q[CTL_XLAT_DIRECT_BIT]
        && P2P_TRANSLATED_I); // [RULE19] [RULE22]
    assign CPL_REDIRECT_O = ctl_q[CTL_CPL_REDIR_BIT] && P2P_CPL_I
        && CPL_IS_READ_I && !CPL_RELAXED_I; // [RULE20]
    assign UP_FORWARD_O = ctl_q[CTL_UP_FWD_BIT]
        && LOWER_REDIRECTED_I; // [RULE21]

endmodule

/* File: rtl/rpe_pkg.sv */
// constants for the root port error log and access control block
package rpe_pkg;
    // register byte offsets in configuration space
    localparam logic [11:0] HDR_LOG_DW2_OFF = 12'h174;
    localparam logic [11:0] HDR_LOG_DW3_OFF = 12'h178;
    localparam logic [11:0] ROOT_ERR_CMD_OFF = 12'h17c;
    localparam logic [11:0] ROOT_ERR_STS_OFF = 12'h180;
    localparam logic [11:0] ERR_SRC_ID_OFF = 12'h184;
    localparam logic [11:0] ACS_HDR_OFF = 12'h190;
    localparam logic [11:0] ACS_CAP_OFF = 12'h194;
    localparam logic [11:0] ACS_CTL_OFF = 12'h196;
    // root error command fields
    localparam int CMD_COR_EN_BIT = 0;
    localparam int CMD_NONFATAL_EN_BIT = 1;
    localparam int CMD_FATAL_EN_BIT = 2;
    localparam int CMD_W = 3;
    // root error status fields
    localparam int STS_COR_BIT = 0;
    localparam int STS_MULT_COR_BIT = 1;
    localparam int STS_UNCOR_BIT = 2;
    localparam int STS_MULT_UNCOR_BIT = 3;
    localparam int STS_FIRST_FATAL_BIT = 4;
    localparam int STS_NONFATAL_SEEN_BIT = 5;
    localparam int STS_FATAL_SEEN_BIT = 6;
    localparam int STS_W = 7;
    localparam int STS_MSGNUM_LSB = 27;
    localparam int MSGNUM_W = 5;
    // error source identity fields
    localparam int SRC_COR_LSB = 0;
    localparam int SRC_UNCOR_LSB = 16;
    localparam int REQ_ID_W = 16;
    // access control capability header
    localparam logic [15:0] ACS_CAP_ID = 16'h000d;
    localparam logic [3:0] ACS_CAP_VER = 4'h1;
    localparam logic [11:0] ACS_NEXT_PTR = 12'h000;
    // access control capability bits, all unimplemented
    localparam logic [6:0] ACS_CAP_BITS = 7'h00;
    // egress vector size, 8'h00 encodes 256 bits
    localparam logic [7:0] ACS_EGRESS_SIZE = 8'h00;
    localparam int ACS_EGRESS_SIZE_LSB = 8;
    // access control enables
    localparam int CTL_SRC_VALID_BIT = 0;
    localparam int CTL_XLAT_BLOCK_BIT = 1;
    localparam int CTL_REQ_REDIR_BIT = 2;
    localparam int CTL_CPL_REDIR_BIT = 3;
    localparam int CTL_UP_FWD_BIT = 4;
    localparam int CTL_EGRESS_BIT = 5;
    localparam int CTL_XLAT_DIRECT_BIT = 6;
    localparam int CTL_W = 7;
    // writable control bits; the egress enable is read-only
    localparam logic [6:0] CTL_WR_MASK = 7'h5f;
    // reset values
    localparam logic [31:0] LOG_RESET = 32'h0000_0000;
    localparam logic [15:0] ID_RESET = 16'h0000;
    // error message classes
    typedef enum logic [1:0] {
        RPE_MSG_COR,
        RPE_MSG_NONFATAL,
        RPE_MSG_FATAL
    } rpe_msg_t;
endpackage

/* File: sim/rpe_checker.sv */
// port assertions for the root port error block
`timescale 1ns/10ps
module rpe_checker
    import rpe_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic WARM_RESET_I,
    input wire logic CFG_RD_I,
    input wire logic [11:0] CFG_ADDR_I,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic [4:0] MSG_NUM_I,
    input wire logic ERR_IRQ_O,
    input wire logic UP_MEM_REQ_I,
    input wire logic [1:0] UP_AT_I,
    input wire logic XLAT_BLOCKED_O,
    input wire logic P2P_REQ_I,
    input wire logic REQ_REDIRECT_O,
    input wire logic P2P_CPL_I,
    input wire logic CPL_IS_READ_I,
    input wire logic CPL_RELAXED_I,
    input wire logic CPL_REDIRECT_O,
    input wire logic LOWER_REDIRECTED_I,
    input wire logic UP_FORWARD_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    wire rd_sts = CFG_RD_I && CFG_ADDR_I[11:2] == ROOT_ERR_STS_OFF[11:2];
    wire rd_hdr = CFG_RD_I && CFG_ADDR_I[11:2] == ACS_HDR_OFF[11:2];
    wire rd_cap = CFG_RD_I && CFG_ADDR_I[11:2] == ACS_CAP_OFF[11:2];
    a_msg_number: assert property (
        rd_sts |=> CFG_RDATA_O[31:27] == $past(MSG_NUM_I))
        else $error("message number field wrong");
    a_cap_header: assert property (
        rd_hdr |=> CFG_RDATA_O == {ACS_NEXT_PTR, ACS_CAP_VER, ACS_CAP_ID})
        else $error("capability header wrong");
    a_cap_bits: assert property (
        rd_cap |=> CFG_RDATA_O[15:0] == 16'h0000)
        else $error("capability bits wrong");
    a_warm_irq: assert property (
        WARM_RESET_I |=> !ERR_IRQ_O)
        else $error("interrupt kept over warm reset");
    a_xlat_block: assert property (
        XLAT_BLOCKED_O |-> UP_MEM_REQ_I && UP_AT_I != 2'h0)
        else $error("block without translated request");
    a_req_redir: assert property (
        REQ_REDIRECT_O |-> P2P_REQ_I)
        else $error("request redirect without request");
    a_cpl_redir: assert property (
        CPL_REDIRECT_O |-> P2P_CPL_I && CPL_IS_READ_I && !CPL_RELAXED_I)
        else $error("completion redirect wrong");
    a_up_forward: assert property (
        UP_FORWARD_O |-> LOWER_REDIRECTED_I)
        else $error("forward without redirected traffic");
    c_irq: cover property (ERR_IRQ_O);
    c_cpl: cover property (CPL_REDIRECT_O);
    c_xlat: cover property (XLAT_BLOCKED_O);
endmodule
bind rpe_root_port_err rpe_checker chk_i (.CLK_SYS_I(CLK_SYS_I),
    .RESET_I(RESET_I), .WARM_RESET_I(WARM_RESET_I), .CFG_RD_I(CFG_RD_I),
    .CFG_ADDR_I(CFG_ADDR_I), .CFG_RDATA_O(CFG_RDATA_O),
    .MSG_NUM_I(MSG_NUM_I), .ERR_IRQ_O(ERR_IRQ_O),
    .UP_MEM_REQ_I(UP_MEM_REQ_I), .UP_AT_I(UP_AT_I),
    .XLAT_BLOCKED_O(XLAT_BLOCKED_O), .P2P_REQ_I(P2P_REQ_I),
    .REQ_REDIRECT_O(REQ_REDIRECT_O), .P2P_CPL_I(P2P_CPL_I),
    .CPL_IS_READ_I(CPL_IS_READ_I), .CPL_RELAXED_I(CPL_RELAXED_I),
    .CPL_REDIRECT_O(CPL_REDIRECT_O),
    .LOWER_REDIRECTED_I(LOWER_REDIRECTED_I), .UP_FORWARD_O(UP_FORWARD_O));

/* File: sim/rpe_err_src.sv */
// downstream device model sending error messages
`timescale 1ns/10ps
module rpe_err_src (
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic [1:0] class_i,
    input wire logic [15:0] req_id_i,
    output logic msg_valid_o,
    output logic [1:0] msg_class_o,
    output logic [15:0] msg_req_id_o
);
    // one message per request, fields scrambled between messages
    always @(posedge clk_i) begin
        msg_valid_o <= send_i;
        msg_class_o <= send_i ? class_i : ~msg_class_o;
        msg_req_id_o <= send_i ? req_id_i : ~msg_req_id_o;
    end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the root port error block
`timescale 1ns/10ps
module tb_top import rpe_pkg::*;;
    logic clk = 0, rst = 1, warm = 0, wr = 0, rd = 0, hwe = 0, snd = 0;
    logic [11:0] addr = 0;
    logic [3:0] be = 0;
    logic [31:0] wdata = 0, dw2 = 0, dw3 = 0, rdata;
    logic [4:0] mnum = 0;
    logic [7:0] sec = 0, sub = 0, bus = 0;
    logic [9:0] tr = 0;
    logic [1:0] scls = 0, mcls;
    logic [15:0] sid = 0, mid, ida, idc;
    logic mval, ack, irq, en;
    wire [4:0] dec;
    logic [31:0] q[$];
    int error_cnt = 0, checks = 0, seed = 37028, i;
    always #5 clk = ~clk;
    rpe_root_port_err dut (.CLK_SYS_I(clk), .RESET_I(rst),
        .WARM_RESET_I(warm), .CFG_WR_I(wr), .CFG_RD_I(rd),
        .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata),
        .CFG_RDATA_O(rdata), .CFG_RD_ACK_O(ack), .MSG_VALID_I(mval),
        .MSG_CLASS_I(mcls), .MSG_REQ_ID_I(mid), .HDR_LOG_WE_I(hwe),
        .HDR_DW2_I(dw2), .HDR_DW3_I(dw3), .MSG_NUM_I(mnum),
        .ERR_IRQ_O(irq), .SEC_BUS_I(sec), .SUB_BUS_I(sub),
        .UP_REQ_I(tr[0]), .UP_REQ_BUS_I(bus), .UP_MEM_REQ_I(tr[1]),
        .UP_AT_I(tr[3:2]), .P2P_REQ_I(tr[4]), .P2P_TRANSLATED_I(tr[5]),
        .P2P_CPL_I(tr[6]), .CPL_IS_READ_I(tr[7]), .CPL_RELAXED_I(tr[8]),
        .LOWER_REDIRECTED_I(tr[9]), .SRC_VIOLATION_O(dec[0]),
        .XLAT_BLOCKED_O(dec[1]), .REQ_REDIRECT_O(dec[2]),
        .CPL_REDIRECT_O(dec[3]), .UP_FORWARD_O(dec[4]));
    rpe_err_src src (.clk_i(clk), .send_i(snd), .class_i(scls),
        .req_id_i(sid), .msg_valid_o(mval), .msg_class_o(mcls),
        .msg_req_id_o(mid));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] b);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        be <= b;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rdx(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        q.push_back(e);
        @(posedge clk);
        rd <= 0;
    endtask
    task automatic msg(input logic [1:0] c, input logic [15:0] id);
        @(posedge clk);
        snd <= 1;
        scls <= c;
        sid <= id;
        @(posedge clk);
        snd <= 0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // read results leave in request order
    always @(posedge clk) begin
        if (ack === 1'b1) begin
            chk(rdata, q.size() ? q.pop_front() : 32'hdead_beef);
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        mnum <= 5'($random(seed));
        wrr(HDR_LOG_DW2_OFF, 32'hffff_ffff, 4'hf);
        wrr(ACS_HDR_OFF, 32'hffff_ffff, 4'hf);
        wrr(12'h1a0, 32'hffff_ffff, 4'hf);
        rdx(HDR_LOG_DW2_OFF, 0);
        rdx(ACS_HDR_OFF, 32'h0001_000d);
        rdx(ACS_CAP_OFF, 0);
        rdx(12'h1a0, 0);
        $display("test defaults done");
        @(posedge clk);
        dw2 <= $random(seed);
        dw3 <= $random(seed);
        hwe <= 1;
        @(posedge clk);
        hwe <= 0;
        rdx(HDR_LOG_DW2_OFF, dw2);
        rdx(HDR_LOG_DW3_OFF, dw3);
        ida = 16'($random(seed));
        idc = ~ida;
        msg(RPE_MSG_COR, ida);
        rdx(ROOT_ERR_STS_OFF, {mnum, 27'h01});
        msg(RPE_MSG_COR, idc);
        msg(2'h3, idc);
        rdx(ROOT_ERR_STS_OFF, {mnum, 27'h03});
        msg(RPE_MSG_NONFATAL, idc);
        msg(RPE_MSG_FATAL, ida);
        rdx(ROOT_ERR_STS_OFF, {mnum, 27'h6f});
        rdx(ROOT_ERR_STS_OFF, {mnum, 27'h6f});
        rdx(ERR_SRC_ID_OFF, {idc, ida});
        for (i = 0; i < 2; i++) begin
            wrr(ROOT_ERR_CMD_OFF, 32'h1 << i, 4'h1);
            repeat (2) @(posedge clk);
            chk(irq, 1);
        end
        $display("test messages done");
        wrr(ROOT_ERR_STS_OFF, 32'h7f, 4'h1);
        rdx(ROOT_ERR_STS_OFF, {mnum, 27'h00});
        msg(RPE_MSG_FATAL, ida);
        rdx(ROOT_ERR_STS_OFF, {mnum, 27'h54});
        for (i = 0; i < 3; i++) begin
            wrr(ROOT_ERR_CMD_OFF, 32'h1 << i, 4'h1);
            repeat (2) @(posedge clk);
            chk(irq, i == 2);
            rdx(ROOT_ERR_CMD_OFF, 32'h1 << i);
        end
        @(posedge clk);
        warm <= 1;
        @(posedge clk);
        warm <= 0;
        rdx(ROOT_ERR_STS_OFF, {mnum, 27'h54});
        rdx(ERR_SRC_ID_OFF, {ida, ida});
        rdx(HDR_LOG_DW3_OFF, dw3);
        wrr(ROOT_ERR_CMD_OFF, 32'h7, 4'he);
        rdx(ROOT_ERR_CMD_OFF, 0);
        chk(irq, 0);
        $display("test status done");
        for (i = 0; i < 64; i++) begin
            if (i == 32) begin
                wrr(ACS_CAP_OFF, 32'hffff_ffff, 4'h4);
                rdx(ACS_CAP_OFF, 32'h005f_0000);
            end
            @(posedge clk);
            tr <= 10'($random(seed));
            {sec, sub, bus} <= 24'($random(seed));
            @(negedge clk);
            en = i >= 32;
            chk(dec[0], en & tr[0] & (bus < sec | bus > sub));
            chk(dec[1], en & tr[1] & (tr[3:2] != 0));
            chk(dec[2], en & tr[4] & !tr[5]);
            chk(dec[3], en & tr[6] & tr[7] & !tr[8]);
            chk(dec[4], en & tr[9]);
        end
        $display("test access control done");
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rdx(ROOT_ERR_STS_OFF, {mnum, 27'h00});
        rdx(ERR_SRC_ID_OFF, 0);
        rdx(HDR_LOG_DW2_OFF, 0);
        rdx(ACS_CAP_OFF, 0);
        repeat (3) @(posedge clk);
        chk(q.size(), 0);
        $display("test cold reset done");
        test_done();
    end
endmodule
